// >>> rtl/sup_pkg.sv
// Purpose: Shared constants and types of the serial USART port.
// Assumes: One 100 MHz clock, clk_sys, and an active-low async reset.
// Notes: Times are kept in their own units, cycle counts derive here.
package sup_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ASYNC_MAX_BPS = 6_250_000;
  localparam int unsigned SYNC_MAX_BPS = 20_000_000;
  localparam int unsigned RTC_HZ = 32_768;
  localparam int unsigned RTC_MAX_BAUD = 9_600;
  // Least clk_sys cycles per bit at the top rates.
  localparam int unsigned ASYNC_MIN_CYC = CLK_HZ / ASYNC_MAX_BPS;
  localparam int unsigned SYNC_MIN_CYC = CLK_HZ / SYNC_MAX_BPS;

  localparam int DATA_W = 9;
  localparam int FRAME_W = 13;
  localparam int DIV_W = 16;

  localparam logic [3:0] OSR_MIN_M1 = 4'h4;
  localparam logic [3:0] DBITS_BASE = 4'h7;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic LINE_IDLE = 1'b1;

  localparam logic [1:0] DLEN_7 = 2'h0;
  localparam logic [1:0] DLEN_8 = 2'h1;
  localparam logic [1:0] DLEN_9 = 2'h2;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;

  typedef struct packed {
    logic [1:0] dlen;
    logic stop2;
    logic [1:0] par;
    logic [3:0] osr;
    logic sync;
    logic master;
    logic smp_fall;
    logic cont_clk;
    logic loop;
    logic rtc_mode;
    logic hwfc;
    logic tx_dis;
    logic brk_tx;
    logic autobaud;
    logic rx_stat;
  } sup_cfg_t;

  typedef struct packed {
    logic rx_rdy;
    logic tx_rdy;
    logic rx_idle;
    logic brk_chg;
    logic frm_err;
    logic par_err;
    logic ovr;
    logic udr;
    logic cts_chg;
    logic noise;
  } sup_evt_t;

  typedef struct packed {
    logic noise;
    logic par_err;
    logic frm_err;
    logic [DATA_W-1:0] data;
  } sup_rxw_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } sup_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BITS = 2'b01,
    RX_BRK = 2'b10
  } sup_rx_st_t;

  typedef enum logic [1:0] {
    AB_IDLE = 2'b00,
    AB_MEAS = 2'b01,
    AB_DONE = 2'b10
  } sup_ab_st_t;

endpackage

// >>> rtl/sup_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_sys.
// Notes: Output changes only when the second and third stages agree.
`timescale 1ns/10ps
module sup_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw pin and settled level.
  input wire logic d,
  output logic q
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic q_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_reg <= s3_reg;
      end
    end
  end

  assign q = q_reg;
endmodule

// >>> rtl/sup_usart.sv
// Purpose: Serial USART port, asynchronous and synchronous, with buffers.
// Assumes: frac_tick comes from the shared fractional divider.
// Notes: Configuration and status are plain ports; no register bus.
`timescale 1ns/10ps
module sup_usart (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration.
  input wire sup_pkg::sup_cfg_t cfg,
  input wire logic [15:0] baud_div,
  input wire logic frac_tick,
  input wire sup_pkg::sup_evt_t int_en,
  // Transmit buffer side.
  input wire logic [8:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive buffer side.
  output sup_pkg::sup_rxw_t rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  // Status and events.
  output sup_pkg::sup_evt_t evt,
  output logic int_req,
  output logic tx_busy,
  output logic rx_busy,
  output logic brk_det,
  output logic cts_state,
  output logic ab_done,
  output logic [15:0] ab_div,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic wake,
  // Serial pins.
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  output logic drv_en,
  input wire logic rtc_clk,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe
);
  import sup_pkg::*;

  logic rxd_s, cts_s, sclk_s, rtc_s;
  logic txd_reg, rts_n_reg, rtc_prev_reg, sclk_prev_reg, sclk_reg;
  logic rx_line, cts_line, cts_prev_reg, cts_ok;
  logic src_tick, os_tick;
  logic [15:0] div_cnt_reg, div_eff;
  logic [3:0] osr, half, nd, nbits, ms_cnt_reg;
  logic m_run, m_sh, m_smp, sh_edge, smp_edge;
  sup_tx_st_t tx_st_reg;
  logic [8:0] tx_buf_reg;
  logic tx_full_reg, tx_go, tx_adv, udr;
  logic [FRAME_W-1:0] tx_sh_reg;
  logic [3:0] tx_left_reg, tx_os_reg;
  sup_rx_st_t rx_st_reg;
  logic [FRAME_W-1:0] rx_sh_reg, rx_frame;
  logic [3:0] rx_idx_reg, rx_os_reg, stop_idx;
  logic [2:0] votes_reg;
  logic rx_prev_reg, rx_noise_reg, rx_full_reg, brk_reg;
  logic rx_start, rx_done, rx_bit, vote_bad, rx_last, rx_brk;
  logic rx_store, rx_ovr, rx_pe, rx_fe;
  logic [8:0] rx_d;
  sup_rxw_t rx_word_reg;
  sup_ab_st_t ab_st_reg;
  logic [3:0] ab_sub_reg;
  logic [15:0] ab_cnt_reg, ab_div_reg;
  logic ab_valid_reg, ab_done_reg, ab_hold, wake_reg;
  sup_evt_t evt_reg;

  function automatic logic par_bit(input logic [8:0] d, input logic [3:0] n,
                                   input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < DATA_W; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction

  function automatic logic [FRAME_W-1:0] make_frame(input logic [8:0] d,
                                                    input logic [3:0] n,
                                                    input logic [1:0] par);
    logic [FRAME_W-1:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < DATA_W; i++) begin
      if (4'(i) < n) begin
        f[i + 1] = d[i];
      end
    end
    if (par[1]) begin
      f[n + 4'h1] = par_bit(d, n, par[0]);
    end
    return f;
  endfunction

  // Pin inputs pass the three-stage filter.
  sup_sync3 #(.RST_VAL(1'b1)) u_rxd (
    .clk_sys(clk_sys), .rst_n(rst_n), .d(rxd), .q(rxd_s));
  sup_sync3 #(.RST_VAL(1'b1)) u_cts (
    .clk_sys(clk_sys), .rst_n(rst_n), .d(cts_n), .q(cts_s));
  sup_sync3 #(.RST_VAL(1'b0)) u_sclk (
    .clk_sys(clk_sys), .rst_n(rst_n), .d(sclk_i), .q(sclk_s));
  sup_sync3 #(.RST_VAL(1'b0)) u_rtc (
    .clk_sys(clk_sys), .rst_n(rst_n), .d(rtc_clk), .q(rtc_s));

  // Frame geometry.
  assign nd = DBITS_BASE + (cfg.dlen[1] ? 4'h2 : {3'h0, cfg.dlen[0]});
  assign nbits = 4'h2 + nd + {3'h0, cfg.par[1]} + {3'h0, cfg.stop2};
  assign stop_idx = nd + 4'h1 + {3'h0, cfg.par[1]};
  assign osr = (cfg.osr < OSR_MIN_M1) ? OSR_MIN_M1 : cfg.osr;
  assign half = 4'((5'(osr) + 5'h01) >> 1);

  // Loopback feeds transmit data and RTS back internally.
  assign rx_line = cfg.loop ? txd_reg : rxd_s;
  assign cts_line = cfg.loop ? rts_n_reg : cts_s;
  assign cts_ok = !cfg.hwfc || !cts_line;

  // Baud generator, ticked by the shared divider or the RTC clock.
  assign src_tick = cfg.rtc_mode ? (rtc_s && !rtc_prev_reg) : frac_tick;
  assign div_eff = ab_valid_reg ? ab_div_reg : baud_div;
  assign os_tick = src_tick && (div_cnt_reg >= div_eff);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= DIV_RST;
      rtc_prev_reg <= 1'b0;
    end else begin
      rtc_prev_reg <= rtc_s;
      if (os_tick) begin
        div_cnt_reg <= DIV_RST;
      end else if (src_tick) begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
    end
  end

  // Synchronous bit clock: master divides os ticks, slave follows sclk.
  assign m_run = cfg.sync && cfg.master &&
                 (tx_st_reg == TX_SEND || cfg.cont_clk);
  assign m_sh = m_run && os_tick && (ms_cnt_reg == CNT_RST);
  assign m_smp = m_run && os_tick && (ms_cnt_reg == half);
  assign sh_edge = cfg.sync && (cfg.master ? m_sh :
      (sclk_s != sclk_prev_reg) && (sclk_s == cfg.smp_fall));
  assign smp_edge = cfg.sync && (cfg.master ? m_smp :
      (sclk_s != sclk_prev_reg) && (sclk_s != cfg.smp_fall));

  // The master bit spans at least SYNC_MIN_CYC clk_sys cycles.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_reg <= CNT_RST;
      sclk_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      if (!m_run) begin
        ms_cnt_reg <= CNT_RST;
      end else if (os_tick) begin
        ms_cnt_reg <= (ms_cnt_reg >= osr) ? CNT_RST : ms_cnt_reg + 4'h1;
      end
      if (m_sh) begin
        sclk_reg <= cfg.smp_fall;
      end else if (m_smp) begin
        sclk_reg <= !cfg.smp_fall;
      end
    end
  end

  // Transmitter with one holding buffer.
  assign tx_ready = !tx_full_reg;
  assign tx_go = tx_st_reg == TX_IDLE && tx_full_reg && !cfg.tx_dis &&
                 cts_ok && !cfg.brk_tx;
  assign tx_adv = cfg.sync ? sh_edge :
                  (os_tick && tx_os_reg >= osr);
  assign udr = cfg.sync && !cfg.master && sh_edge &&
               tx_st_reg == TX_IDLE && !tx_full_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_reg <= '0;
      tx_full_reg <= 1'b0;
    end else if (tx_valid && !tx_full_reg) begin
      tx_buf_reg <= tx_data;
      tx_full_reg <= 1'b1;
    end else if (tx_go) begin
      tx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_reg <= TX_IDLE;
      tx_sh_reg <= '1;
      tx_left_reg <= CNT_RST;
      tx_os_reg <= CNT_RST;
    end else begin
      case (tx_st_reg)
        TX_IDLE: begin
          if (tx_go) begin
            tx_sh_reg <= make_frame(tx_buf_reg, nd, cfg.par);
            tx_left_reg <= nbits;
            tx_os_reg <= CNT_RST;
            tx_st_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (os_tick) begin
            tx_os_reg <= (tx_os_reg >= osr) ? CNT_RST : tx_os_reg + 4'h1;
          end
          if (tx_adv) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[FRAME_W-1:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
            if (tx_left_reg == 4'h1) begin
              tx_st_reg <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_st_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Line outputs: break forces low, the idle line stays high.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txd_reg <= LINE_IDLE;
      rts_n_reg <= 1'b1;
    end else begin
      if (cfg.brk_tx) begin
        txd_reg <= 1'b0;
      end else begin
        txd_reg <= (tx_st_reg == TX_SEND) ? tx_sh_reg[0] : LINE_IDLE;
      end
      rts_n_reg <= cfg.hwfc ? rx_full_reg : 1'b0;
    end
  end

  // Receiver bit decision.
  assign ab_hold = cfg.autobaud && !ab_valid_reg;
  assign rx_start = rx_st_reg == RX_IDLE && !ab_hold &&
      (cfg.sync ? (smp_edge && !rx_line) : (rx_prev_reg && !rx_line));
  assign rx_bit = cfg.sync ? rx_line :
      ((votes_reg[0] & votes_reg[1]) | (votes_reg[0] & votes_reg[2]) |
       (votes_reg[1] & votes_reg[2]));
  assign vote_bad = !cfg.sync && (votes_reg != 3'h0) &&
                    (votes_reg != 3'h7);
  assign rx_done = rx_st_reg == RX_BITS &&
      (cfg.sync ? smp_edge : (os_tick && rx_os_reg >= osr));
  assign rx_last = rx_idx_reg == nbits - 4'h1;

  always_comb begin
    rx_frame = rx_sh_reg;
    rx_frame[rx_idx_reg] = rx_bit;
    rx_d = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (4'(i) < nd) begin
        rx_d[i] = rx_frame[i + 1];
      end
    end
    rx_brk = 1'b1;
    for (int i = 0; i < FRAME_W; i++) begin
      if (4'(i) < nbits && rx_frame[i]) begin
        rx_brk = 1'b0;
      end
    end
  end

  assign rx_pe = cfg.par[1] &&
      (rx_frame[nd + 4'h1] != par_bit(rx_d, nd, cfg.par[0]));
  assign rx_fe = !rx_frame[stop_idx] ||
      (cfg.stop2 && !rx_frame[stop_idx + 4'h1]);
  assign rx_store = rx_done && rx_last && !rx_brk && !rx_ovr;
  assign rx_ovr = rx_done && rx_last && !rx_brk &&
                  rx_full_reg && !rx_ready;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg <= RX_IDLE;
      rx_sh_reg <= '1;
      rx_idx_reg <= CNT_RST;
      rx_os_reg <= CNT_RST;
      votes_reg <= 3'h7;
      rx_prev_reg <= LINE_IDLE;
      rx_noise_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_line;
      case (rx_st_reg)
        RX_IDLE: begin
          if (rx_start) begin
            rx_st_reg <= RX_BITS;
            rx_os_reg <= CNT_RST;
            rx_noise_reg <= 1'b0;
            rx_sh_reg <= '1;
            rx_idx_reg <= cfg.sync ? 4'h1 : CNT_RST;
            rx_sh_reg[0] <= 1'b0;
          end
        end
        RX_BITS: begin
          if (os_tick) begin
            rx_os_reg <= (rx_os_reg >= osr) ? CNT_RST : rx_os_reg + 4'h1;
            if (rx_os_reg + 4'h1 >= half && rx_os_reg <= half + 4'h1) begin
              votes_reg <= {votes_reg[1:0], rx_line};
            end
          end
          if (rx_done) begin
            rx_sh_reg <= rx_frame;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            rx_noise_reg <= rx_noise_reg | vote_bad;
            if (rx_idx_reg == CNT_RST && rx_bit) begin
              rx_st_reg <= RX_IDLE;
            end else if (rx_last && rx_brk) begin
              brk_reg <= 1'b1;
              rx_st_reg <= RX_BRK;
            end else if (rx_last) begin
              rx_st_reg <= RX_IDLE;
            end
          end
        end
        RX_BRK: begin
          if (rx_line) begin
            brk_reg <= 1'b0;
            rx_st_reg <= RX_IDLE;
          end
        end
        default: begin
          rx_st_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer; a new character wins over a same-cycle read.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_reg <= 1'b0;
      rx_word_reg <= '0;
    end else if (rx_store) begin
      rx_full_reg <= 1'b1;
      rx_word_reg.data <= rx_d;
      rx_word_reg.noise <= cfg.rx_stat && (rx_noise_reg || vote_bad);
      rx_word_reg.par_err <= cfg.rx_stat && rx_pe;
      rx_word_reg.frm_err <= cfg.rx_stat && rx_fe;
    end else if (rx_ready) begin
      rx_full_reg <= 1'b0;
    end
  end

  // Autobaud: count start-bit length in oversample units.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ab_st_reg <= AB_IDLE;
      ab_sub_reg <= CNT_RST;
      ab_cnt_reg <= DIV_RST;
      ab_div_reg <= DIV_RST;
      ab_valid_reg <= 1'b0;
      ab_done_reg <= 1'b0;
    end else begin
      ab_done_reg <= 1'b0;
      case (ab_st_reg)
        AB_IDLE: begin
          if (ab_hold && rx_prev_reg && !rx_line) begin
            ab_st_reg <= AB_MEAS;
            ab_sub_reg <= CNT_RST;
            ab_cnt_reg <= DIV_RST;
          end
        end
        AB_MEAS: begin
          if (src_tick) begin
            ab_sub_reg <= (ab_sub_reg >= osr) ? CNT_RST : ab_sub_reg + 4'h1;
            if (ab_sub_reg >= osr && ab_cnt_reg != 16'hffff) begin
              ab_cnt_reg <= ab_cnt_reg + 16'h0001;
            end
          end
          if (rx_line) begin
            ab_div_reg <= (ab_cnt_reg == DIV_RST) ? DIV_RST :
                          ab_cnt_reg - 16'h0001;
            ab_valid_reg <= 1'b1;
            ab_done_reg <= 1'b1;
            ab_st_reg <= AB_DONE;
          end
        end
        AB_DONE: begin
          if (!cfg.autobaud) begin
            ab_valid_reg <= 1'b0;
            ab_st_reg <= AB_IDLE;
          end
        end
        default: begin
          ab_st_reg <= AB_IDLE;
        end
      endcase
    end
  end

  // Events, wake-up and flow-control change detection.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= '0;
      cts_prev_reg <= 1'b1;
      wake_reg <= 1'b0;
    end else begin
      cts_prev_reg <= cts_line;
      evt_reg.rx_rdy <= rx_store;
      evt_reg.tx_rdy <= tx_go;
      evt_reg.rx_idle <= rx_done && rx_last;
      evt_reg.brk_chg <= (rx_done && rx_last && rx_brk) ||
                         (rx_st_reg == RX_BRK && rx_line);
      evt_reg.frm_err <= rx_done && rx_last && !rx_brk && rx_fe;
      evt_reg.par_err <= rx_done && rx_last && !rx_brk && rx_pe;
      evt_reg.ovr <= rx_ovr;
      evt_reg.udr <= udr;
      evt_reg.cts_chg <= cts_line != cts_prev_reg;
      evt_reg.noise <= rx_done && vote_bad;
      wake_reg <= (cfg.rtc_mode && rx_store) ||
                  (cfg.sync && !cfg.master && rx_done && rx_last);
    end
  end

  assign evt = evt_reg;
  assign int_req = |(evt_reg & int_en);
  assign rx_word = rx_word_reg;
  assign rx_valid = rx_full_reg;
  assign tx_busy = tx_st_reg == TX_SEND;
  assign rx_busy = rx_st_reg != RX_IDLE;
  assign brk_det = brk_reg;
  assign cts_state = !cts_line;
  assign ab_done = ab_done_reg;
  assign ab_div = ab_div_reg;
  assign dma_tx_req = !tx_full_reg;
  assign dma_rx_req = rx_full_reg;
  assign wake = wake_reg;
  assign txd = txd_reg;
  assign rts_n = rts_n_reg;
  assign drv_en = tx_st_reg == TX_SEND;
  assign sclk_o = sclk_reg;
  assign sclk_oe = cfg.sync && cfg.master;
endmodule

// >>> test/sup_usart_props.sv
// Purpose: Port-level checks of the serial USART port.
// Assumes: Bound to sup_usart; one clock domain.
// Notes: Framing checks apply to asynchronous operation.
`timescale 1ns/10ps
module sup_usart_props (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports.
  input wire sup_pkg::sup_cfg_t cfg,
  input wire sup_pkg::sup_evt_t int_en,
  input wire sup_pkg::sup_evt_t evt,
  input wire sup_pkg::sup_rxw_t rx_word,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire logic tx_busy,
  input wire logic txd,
  input wire logic drv_en,
  input wire logic int_req,
  input wire logic cts_state,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req
);
  import sup_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_idle_high;
    !tx_busy && !cfg.brk_tx && !cfg.sync |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low idle");
  property p_start;
    $rose(tx_busy) && !cfg.sync |-> evt.tx_rdy ##1 !txd;
  endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_drv;
    tx_busy |-> drv_en;
  endproperty
  a_drv: assert property (p_drv) else $error("driver off in frame");
  property p_int;
    int_req == |(evt & int_en);
  endproperty
  a_int: assert property (p_int) else $error("interrupt mismatch");
  property p_dma;
    dma_tx_req == tx_ready && dma_rx_req == rx_valid;
  endproperty
  a_dma: assert property (p_dma) else $error("dma request mismatch");
  property p_cts;
    cfg.hwfc && !cts_state && !tx_busy |=> !tx_busy;
  endproperty
  a_cts: assert property (p_cts) else $error("sent without cts");
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_word);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx lost");
  property p_rx_rdy;
    $rose(rx_valid) |-> evt.rx_rdy;
  endproperty
  a_rx_rdy: assert property (p_rx_rdy) else $error("no rx event");
endmodule
bind sup_usart sup_usart_props i_props (.clk_sys, .rst_n, .cfg, .int_en,
  .evt, .rx_word, .rx_valid, .rx_ready, .tx_ready, .tx_busy, .txd, .drv_en,
  .int_req, .cts_state, .dma_tx_req, .dma_rx_req);

// >>> test/sup_uart_peer.sv
// Purpose: Remote asynchronous serial device.
// Assumes: BIT clk_sys cycles per bit.
// Notes: Drives its lines at falling clock edges.
`timescale 1ns/10ps
module sup_uart_peer #(
  parameter int BIT = 16
) (
  // Clock.
  input wire logic clk_sys,
  // Lines toward the port.
  output logic rxd,
  output logic cts_n
);
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  // Shifts a frame out first bit first, then idles the line high.
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      rxd = f[i];
      repeat (BIT - 1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    rxd = 1'b1;
  endtask
  task automatic set_cts(input logic v);
    @(negedge clk_sys);
    cts_n = v;
  endtask
endmodule

// >>> test/tb_sup_usart.sv
// Purpose: Self-checking bench of the serial USART port.
// Assumes: frac_tick every cycle, so one bit lasts (osr+1)*(baud_div+1) cycles.
// Notes: Inputs change at the falling clock edge.
`timescale 1ns/10ps
module tb_sup_usart;
  import sup_pkg::*;
  localparam int BIT = 16;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  sup_cfg_t cfg;
  sup_evt_t int_en, evt, evt_seen;
  sup_rxw_t rx_word;
  logic [8:0] tx_data = 9'h000;
  logic [15:0] baud_div = 16'h0000;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_ready, rx_valid, int_req, tx_busy, rx_busy, brk_det, cts_state;
  logic ab_done, dma_tx_req, dma_rx_req, wake, rxd, txd, cts_n, rts_n;
  logic drv_en, sclk_o, sclk_oe;
  logic [15:0] ab_div;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [1:0] t_len [3] = '{DLEN_7, DLEN_9, DLEN_8};
  logic t_stop [3] = '{1'b1, 1'b0, 1'b0};
  logic [1:0] t_par [3] = '{PAR_ODD, PAR_NONE, PAR_EVEN};
  logic [8:0] t_dat [3] = '{9'h05a, 9'h1c3, 9'h0a5};
  always #5 clk_sys = ~clk_sys;
  sup_usart i_dut (.clk_sys, .rst_n, .cfg, .baud_div,
    .frac_tick(1'b1), .int_en, .tx_data, .tx_valid, .tx_ready, .rx_word,
    .rx_valid, .rx_ready, .evt, .int_req, .tx_busy, .rx_busy, .brk_det,
    .cts_state, .ab_done, .ab_div, .dma_tx_req, .dma_rx_req, .wake, .rxd,
    .txd, .cts_n, .rts_n, .drv_en, .rtc_clk(1'b0), .sclk_i(1'b0), .sclk_o,
    .sclk_oe);
  sup_uart_peer #(.BIT(BIT)) i_peer (.clk_sys, .rxd, .cts_n);
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    evt_seen <= evt_seen | evt;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int frame(input int k, output logic [12:0] f);
    int nd;
    int p;
    nd = 7 + int'(t_len[k]);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nd; i++)
      f[1 + i] = t_dat[k][i];
    p = 1 + nd;
    if (t_par[k] != PAR_NONE) begin
      f[p] = ^(t_dat[k] & ~(9'h1ff << nd)) ^ t_par[k][0];
      p++;
    end
    return p + 1 + int'(t_stop[k]);
  endfunction
  task automatic put_tx(input logic [8:0] d);
    @(negedge clk_sys);
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    tx_valid = 1'b0;
  endtask
  task automatic get_frame(input int n, output logic [12:0] f);
    f = '1;
    while (txd !== 1'b0) @(negedge clk_sys);
    repeat (BIT / 2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (BIT) @(negedge clk_sys);
    end
  endtask
  task automatic take(input logic [8:0] d, input logic [2:0] st);
    while (rx_valid !== 1'b1) @(negedge clk_sys);
    chk({4'h0, rx_word}, {4'h0, st, d});
    rx_ready = 1'b1;
    @(negedge clk_sys);
    rx_ready = 1'b0;
  endtask
  // Sends and receives one frame of every format in the table.
  task automatic t_formats();
    logic [12:0] f, g;
    int n;
    for (int k = 0; k < 3; k++) begin
      @(negedge clk_sys);
      cfg.dlen = t_len[k];
      cfg.stop2 = t_stop[k];
      cfg.par = t_par[k];
      cfg.rx_stat = (k != 0);
      n = frame(k, f);
      put_tx(t_dat[k]);
      get_frame(n, g);
      chk({3'h0, g}, {3'h0, f});
      i_peer.send(f, n);
      take(t_dat[k] & ~(9'h1ff << (7 + t_len[k])), 3'h0);
    end
  endtask
  // Bad parity, low stop bit, then a frame arriving while full.
  task automatic t_errors();
    logic [12:0] f;
    int n;
    n = frame(2, f);
    i_peer.send(f ^ 13'h0200, n);
    take(t_dat[2], 3'h2);
    i_peer.send(f & 13'h1bff, n);
    take(t_dat[2], 3'h1);
    evt_seen = '0;
    i_peer.send(f, n);
    i_peer.send(f, n);
    repeat (BIT) @(negedge clk_sys);
    chk({15'h0, evt_seen.ovr}, 16'h0001);
    take(t_dat[2], 3'h0);
  endtask
  // Transmission waits for clear-to-send.
  task automatic t_flow();
    logic [12:0] f, g;
    int n;
    cfg.hwfc = 1'b1;
    evt_seen = '0;
    i_peer.set_cts(1'b1);
    repeat (8) @(negedge clk_sys);
    chk({14'h0, rts_n, evt_seen.cts_chg}, 16'h0001);
    n = frame(2, f);
    put_tx(t_dat[2]);
    repeat (4 * BIT) @(negedge clk_sys);
    chk({14'h0, tx_busy, txd}, 16'h0001);
    i_peer.set_cts(1'b0);
    get_frame(n, g);
    chk({3'h0, g}, {3'h0, f});
  endtask
  // Loopback at half rate: the own frame returns on the receive side.
  task automatic t_loop();
    @(negedge clk_sys);
    cfg.loop = 1'b1;
    baud_div = 16'h0001;
    put_tx(t_dat[2]);
    repeat (BIT) @(negedge clk_sys);
    chk({14'h0, drv_en, txd}, 16'h0002);
    take(t_dat[2], 3'h0);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cfg = '0;
    cfg.osr = 4'hf;
    int_en = '1;
    evt_seen = '0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    t_formats();
    t_errors();
    t_flow();
    t_loop();
    complete_run();
  end
endmodule
